/* hw/sau_addr_calc.sv */
// Address arithmetic for data, vector and descriptor accesses.
// Purely combinational; all inputs come from flops of the unit.
`timescale 1ns/1ps
module sau_addr_calc (
  input wire logic prot,
  input wire logic [15:0] sel,
  input wire logic [15:0] off,
  input wire logic [15:0] stack_pointer,
  input wire sau_pkg::sau_cmd_s cmd,
  input wire logic [23:0] seg_base,
  input wire logic [23:0] vt_base,
  input wire logic [23:0] dtb,
  input wire logic [7:0] vec,
  input wire logic [1:0] desc_word,
  output logic [23:0] data_addr,
  output logic [23:0] vec_addr,
  output logic [23:0] desc_addr,
  output logic [23:0] seg_real,
  output logic wrap
);
  logic [15:0] eff_off;

  // Pushes address the word below the stack pointer
  assign eff_off = cmd.stack ? 16'(stack_pointer - sau_pkg::STACK_STEP) : off;
  assign wrap = cmd.stack ? (stack_pointer < sau_pkg::STACK_STEP)
                          : (cmd.word & (off == sau_pkg::OFFSET_TOP));
  assign data_addr = prot ? 24'(seg_base + {8'h00, eff_off})
                          : sau_pkg::real_addr(sel, eff_off);
  assign vec_addr = 24'(vt_base + {14'h0000, vec, 2'b00});
  // Eight bytes per entry, four word reads
  assign desc_addr = 24'(dtb + {5'h00, sel[15:3], 3'b000}
                         + {21'h000000, desc_word, 1'b0});
  assign seg_real = {4'h0, sel, 4'h0};
endmodule

/* hw/sau_bus_cycle.sv */
// One local bus cycle: holds the request until the memory answers.
// Assumes mem_ready is synchronous to pclk.
`timescale 1ns/1ps
module sau_bus_cycle (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire sau_pkg::sau_bus_s req,
  input wire logic mem_ready,
  input wire logic [15:0] mem_rdata,
  output logic mem_valid,
  output sau_pkg::sau_bus_s mem_bus,
  output logic done,
  output logic [15:0] rdata
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_valid <= 1'b0;
      mem_bus <= '0;
      done <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (start) begin
        mem_valid <= 1'b1;
        mem_bus <= req;
      end else if (mem_valid && mem_ready) begin
        mem_valid <= 1'b0;
        mem_bus <= '0;
        done <= 1'b1;
        // Halt and shutdown cycles carry no data
        if (!mem_bus.halt) begin
          rdata <= mem_rdata;
        end
      end
    end
  end
endmodule

/* hw/sau_pkg.sv */
// Shared constants, types and helpers for the segment address unit.
// Assumes a single 200 MHz clock and an APB register port.
package sau_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ARG = 8'h04;
  localparam logic [7:0] OFF_LIM = 8'h08;
  localparam logic [7:0] OFF_STACK_POINTER = 8'h0c;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_PADDR = 8'h14;
  localparam logic [7:0] OFF_VTB = 8'h18;
  localparam logic [7:0] OFF_VTL = 8'h1c;
  localparam logic [7:0] OFF_STATUS_WORD = 8'h20;
  localparam logic [7:0] OFF_SEGB = 8'h24;
  localparam logic [7:0] OFF_DTB = 8'h28;
  localparam logic [7:0] OFF_RDATA = 8'h2c;

  // ----------------------------------------
  // Reset values and fixed figures
  // ----------------------------------------
  localparam logic [15:0] RST_STATUS_WORD = 16'hfff0;
  localparam logic [15:0] RST_VT_LIMIT = 16'h03ff;
  localparam logic [23:0] RST_VT_BASE = 24'h000000;
  localparam logic [15:0] RST_CS = 16'hf000;
  localparam logic [15:0] RST_IP = 16'hfff0;
  localparam logic [7:0] VEC_NONE = 8'h00;
  localparam logic [7:0] VEC_LIMIT = 8'h08;
  localparam logic [7:0] VEC_COPROC = 8'h09;
  localparam logic [7:0] VEC_NOT_PRESENT = 8'h0b;
  localparam logic [7:0] VEC_SEG_OVERRUN = 8'h0d;
  localparam logic [15:0] NMI_MIN_LIMIT = 16'h000f;
  localparam logic [15:0] NMI_MIN_STACK_POINTER = 16'h0005;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [15:0] OFFSET_TOP = 16'hffff;
  localparam logic [1:0] DESC_LAST_WORD = 2'h3;
  localparam logic [1:0] DESC_BASE_LO_WORD = 2'h1;
  localparam logic [1:0] DESC_BASE_HI_WORD = 2'h2;
  localparam int DESC_PRESENT_BIT = 15;
  localparam int STAT_EXC_BIT = 4;
  localparam logic [23:0] HALT_ADDR = 24'h000002;
  localparam logic [23:0] SHUTDOWN_ADDR = 24'h000000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ACCESS = 4'h1,
    OP_LOAD_SEG = 4'h2,
    OP_LOAD_TABLE = 4'h3,
    OP_LOAD_STATUS = 4'h4,
    OP_INT = 4'h5,
    OP_NMI = 4'h6,
    OP_HALT = 4'h7,
    OP_COPROC = 4'h8
  } sau_op_e;

  typedef struct packed {
    logic stack;
    logic word;
    sau_op_e op;
  } sau_cmd_s;

  typedef struct packed {
    logic [23:0] addr;
    logic byte_high_enable_n;
    logic halt;
  } sau_bus_s;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [23:0] real_addr(input logic [15:0] sel, input logic [15:0] off);
    logic [19:0] sum;
    sum = 20'({sel, 4'h0} + {4'h0, off});
    real_addr = {4'h0, sum};
  endfunction

  function automatic logic vec_fits(input logic [7:0] vec, input logic [15:0] limit);
    vec_fits = ({6'h00, vec, 2'b11} <= limit);
  endfunction

  function automatic sau_bus_s mk_req(input logic [23:0] a, input logic hi_n,
                                      input logic halt);
    mk_req = '{addr: a, byte_high_enable_n: hi_n, halt: halt};
  endfunction

endpackage

/* hw/sau_top.sv */
// Segment address unit: real and protected mode address generation,
// vector table, descriptor fetch, halt and shutdown signalling.
// Assumes an APB master on pclk and a synchronous memory answering mem_valid.
//
// Functional notes
// - Real mode reaches one megabyte with twenty address lines and byte high.
// - Upper four address lines carry no meaning in real mode.
// - Real mode selector is segment address bits 19..4.
// - Real segments are 64K, readable, writable, executable, unchecked.
// - Word at offset FFFF or wrap past segment end raises exception.
// - First fetch after reset at FFFF0, code F000, pointer FFF0.
// - Vector table occupies 00000 to 003FF in real mode.
// - Exceptions keep prior state, except stack push and pop forms.
// - Load-table instruction sets 24-bit base and 16-bit limit.
// - Reset sets table base 000000 and limit 03FF.
// - Halt and shutdown use a halt cycle; A1 high halt, low shutdown.
// - Exception 8 or 13 with vector beyond limit enters shutdown.
// - Real stack wrap with odd stack pointer enters shutdown.
// - NMI leaves shutdown only if limit at least 000F and pointer above 5.
// - Setting protection enable via status load enters protected mode.
// - Protected mode uses all 24 address lines and byte high.
// - Unmapped address raises a restartable exception.
// - Protected address is segment base plus 16-bit offset.
// - Every protected segment load fetches its table entry itself.
// - Each table entry is eight bytes.
// - Table entry reads are locked bus operations.
// - Vectors: 8 table limit, 9 coprocessor overrun, 13 segment overrun.
// - Protection enable stays set until reset.
// - Reset loads status word FFF0, real mode.
`timescale 1ns/1ps
module sau_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mem_ready,
  input wire logic [15:0] mem_rdata,
  output logic mem_valid,
  output sau_pkg::sau_bus_s mem_bus,
  output logic mem_lock
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_BUS = 3'b011,
    ST_DISSUE = 3'b100,
    ST_DWAIT = 3'b101
  } sau_state_e;

  sau_state_e state;
  sau_pkg::sau_cmd_s cmd;
  sau_pkg::sau_bus_s bus_req;
  logic [31:0] arg;
  logic [15:0] lim_arg;
  logic [15:0] stack_pointer;
  logic [15:0] machine_status_word;
  logic [15:0] vt_limit;
  logic [23:0] vt_base;
  logic [23:0] dtb;
  logic [23:0] seg_base;
  logic [23:0] desc_base;
  logic [23:0] paddr_r;
  logic seg_present;
  logic desc_present;
  logic [1:0] desc_idx;
  logic shutdown;
  logic halted;
  logic exc_valid;
  logic [7:0] exc_vec;
  logic bus_go;
  logic bus_done;
  logic [15:0] bus_rdata;
  logic prot;
  logic busy;
  logic wr_en;
  logic cmd_go;
  logic ignore;
  logic in_exec;
  logic nmi_ok;
  logic stk_fault;
  logic rd_hit;
  logic [31:0] rd_mux;
  logic ex_raise;
  logic ex_shut;
  logic ex_bus;
  logic [7:0] ex_vec;
  logic [23:0] ex_addr;
  logic [23:0] data_addr;
  logic [23:0] vec_addr;
  logic [23:0] desc_addr;
  logic [23:0] seg_real;
  logic wrap;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign prot = machine_status_word[0];
  assign busy = (state != ST_IDLE);
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign cmd_go = wr_en & (paddr == sau_pkg::OFF_CMD) & ~busy;
  assign pslverr = psel & penable & (~rd_hit | (pwrite & (paddr == sau_pkg::OFF_CMD) & busy));

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    unique case (paddr)
      sau_pkg::OFF_CMD: rd_mux = {26'h0000000, cmd};
      sau_pkg::OFF_ARG: rd_mux = arg;
      sau_pkg::OFF_LIM: rd_mux = {16'h0000, lim_arg};
      sau_pkg::OFF_STACK_POINTER: rd_mux = {16'h0000, stack_pointer};
      sau_pkg::OFF_STAT: rd_mux = {16'h0000, exc_vec, 3'b000, exc_valid, halted, shutdown, prot,
                                   busy};
      sau_pkg::OFF_PADDR: rd_mux = {8'h00, paddr_r};
      sau_pkg::OFF_VTB: rd_mux = {8'h00, vt_base};
      sau_pkg::OFF_VTL: rd_mux = {16'h0000, vt_limit};
      sau_pkg::OFF_STATUS_WORD: rd_mux = {16'h0000, machine_status_word};
      sau_pkg::OFF_SEGB: rd_mux = {7'h00, seg_present, seg_base};
      sau_pkg::OFF_DTB: rd_mux = {8'h00, dtb};
      sau_pkg::OFF_RDATA: rd_mux = {16'h0000, bus_rdata};
      default: rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Software-written registers
  // ----------------------------------------
  // Read data is captured in the setup phase so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      arg <= 32'h00000000;
      lim_arg <= 16'h0000;
      dtb <= 24'h000000;
      cmd <= '0;
    end else begin
      if (psel && !penable) begin
        prdata <= rd_mux;
      end
      if (wr_en && paddr == sau_pkg::OFF_ARG) begin
        arg <= pwdata;
      end
      if (wr_en && paddr == sau_pkg::OFF_LIM) begin
        lim_arg <= pwdata[15:0];
      end
      if (wr_en && paddr == sau_pkg::OFF_DTB) begin
        dtb <= pwdata[23:0];
      end
      if (cmd_go) begin
        cmd <= sau_pkg::sau_cmd_s'(pwdata[5:0]);
      end
    end
  end

  // ----------------------------------------
  // Address arithmetic
  // ----------------------------------------
  sau_addr_calc u_calc (
    .prot(prot),
    .sel(arg[31:16]),
    .off(arg[15:0]),
    .stack_pointer(stack_pointer),
    .cmd(cmd),
    .seg_base(seg_base),
    .vt_base(vt_base),
    .dtb(dtb),
    .vec(arg[7:0]),
    .desc_word(desc_idx),
    .data_addr(data_addr),
    .vec_addr(vec_addr),
    .desc_addr(desc_addr),
    .seg_real(seg_real),
    .wrap(wrap)
  );

  // ----------------------------------------
  // Command outcome
  // ----------------------------------------
  // Shutdown admits only NMI; halt admits NMI and INT
  assign ignore = shutdown ? (cmd.op != sau_pkg::OP_NMI)
                           : (halted & (cmd.op != sau_pkg::OP_NMI) & (cmd.op != sau_pkg::OP_INT));
  assign in_exec = (state == ST_EXEC) & ~ignore;
  assign nmi_ok = (vt_limit >= sau_pkg::NMI_MIN_LIMIT)
                  & (stack_pointer > sau_pkg::NMI_MIN_STACK_POINTER);
  assign stk_fault = ((cmd.op == sau_pkg::OP_ACCESS) | (cmd.op == sau_pkg::OP_INT))
                     & cmd.stack & wrap & stack_pointer[0] & ~prot;

  always_comb begin
    ex_raise = 1'b0;
    ex_vec = sau_pkg::VEC_NONE;
    ex_bus = 1'b0;
    ex_addr = data_addr;
    unique case (cmd.op)
      sau_pkg::OP_ACCESS: begin
        if (wrap) begin
          ex_raise = 1'b1;
          ex_vec = sau_pkg::VEC_SEG_OVERRUN;
        end else if (prot && !seg_present) begin
          ex_raise = 1'b1;
          ex_vec = sau_pkg::VEC_NOT_PRESENT;
        end else begin
          ex_bus = 1'b1;
        end
      end
      sau_pkg::OP_INT: begin
        if (!sau_pkg::vec_fits(arg[7:0], vt_limit)) begin
          ex_raise = 1'b1;
          ex_vec = sau_pkg::VEC_LIMIT;
        end else begin
          ex_bus = 1'b1;
          ex_addr = vec_addr;
        end
      end
      sau_pkg::OP_COPROC: begin
        ex_raise = 1'b1;
        ex_vec = sau_pkg::VEC_COPROC;
      end
      default: begin
        ex_raise = 1'b0;
      end
    endcase
    ex_shut = stk_fault | (ex_raise & ~sau_pkg::vec_fits(ex_vec, vt_limit));
  end

  // ----------------------------------------
  // Sequencer and bus requests
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_BOOT;
      bus_go <= 1'b0;
      bus_req <= '0;
      mem_lock <= 1'b0;
      desc_idx <= 2'h0;
    end else begin
      bus_go <= 1'b0;
      unique case (state)
        ST_BOOT: begin
          bus_go <= 1'b1;
          bus_req <= sau_pkg::mk_req(sau_pkg::real_addr(sau_pkg::RST_CS, sau_pkg::RST_IP),
                                     1'b0, 1'b0);
          state <= ST_BUS;
        end
        ST_IDLE: begin
          if (cmd_go) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (ignore) begin
            state <= ST_IDLE;
          end else if (ex_shut) begin
            bus_go <= 1'b1;
            bus_req <= sau_pkg::mk_req(sau_pkg::SHUTDOWN_ADDR, 1'b1, 1'b1);
            state <= ST_BUS;
          end else if (cmd.op == sau_pkg::OP_HALT) begin
            bus_go <= 1'b1;
            bus_req <= sau_pkg::mk_req(sau_pkg::HALT_ADDR, 1'b1, 1'b1);
            state <= ST_BUS;
          end else if (cmd.op == sau_pkg::OP_LOAD_SEG && prot) begin
            desc_idx <= 2'h0;
            mem_lock <= 1'b1;
            state <= ST_DISSUE;
          end else if (ex_bus) begin
            bus_go <= 1'b1;
            // Upper lines are zero for real-mode data accesses; only twenty are meaningful
            bus_req <= sau_pkg::mk_req(ex_addr, ~(cmd.word | ex_addr[0]), 1'b0);
            state <= ST_BUS;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_BUS: begin
          if (bus_done) begin
            state <= ST_IDLE;
          end
        end
        ST_DISSUE: begin
          bus_go <= 1'b1;
          bus_req <= sau_pkg::mk_req(desc_addr, 1'b0, 1'b0);
          state <= ST_DWAIT;
        end
        ST_DWAIT: begin
          if (bus_done) begin
            if (desc_idx == sau_pkg::DESC_LAST_WORD) begin
              mem_lock <= 1'b0;
              state <= ST_IDLE;
            end else begin
              desc_idx <= 2'(desc_idx + 2'h1);
              state <= ST_DISSUE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  sau_bus_cycle u_bus (
    .pclk(pclk),
    .presetn(presetn),
    .start(bus_go),
    .req(bus_req),
    .mem_ready(mem_ready),
    .mem_rdata(mem_rdata),
    .mem_valid(mem_valid),
    .mem_bus(mem_bus),
    .done(bus_done),
    .rdata(bus_rdata)
  );

  // ----------------------------------------
  // Mode and vector table
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      machine_status_word <= sau_pkg::RST_STATUS_WORD;
      vt_base <= sau_pkg::RST_VT_BASE;
      vt_limit <= sau_pkg::RST_VT_LIMIT;
    end else if (in_exec) begin
      if (cmd.op == sau_pkg::OP_LOAD_STATUS) begin
        // Enable bit is sticky: software may set but never clear it
        machine_status_word <= arg[15:0] | {15'h0000, machine_status_word[0]};
      end
      if (cmd.op == sau_pkg::OP_LOAD_TABLE) begin
        vt_base <= arg[23:0];
        vt_limit <= lim_arg;
      end
    end
  end

  // ----------------------------------------
  // Segment base
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_base <= 24'h000000;
      seg_present <= 1'b1;
      desc_base <= 24'h000000;
      desc_present <= 1'b0;
    end else begin
      if (in_exec && cmd.op == sau_pkg::OP_LOAD_SEG && !prot) begin
        seg_base <= seg_real;
        seg_present <= 1'b1;
      end
      if (state == ST_DWAIT && bus_done) begin
        if (desc_idx == sau_pkg::DESC_BASE_LO_WORD) begin
          desc_base[15:0] <= bus_rdata;
        end
        if (desc_idx == sau_pkg::DESC_BASE_HI_WORD) begin
          desc_base[23:16] <= bus_rdata[7:0];
          desc_present <= bus_rdata[sau_pkg::DESC_PRESENT_BIT];
        end
        // Commit only after the whole entry is read
        if (desc_idx == sau_pkg::DESC_LAST_WORD) begin
          seg_base <= desc_base;
          seg_present <= desc_present;
        end
      end
    end
  end

  // ----------------------------------------
  // Status, stack pointer, last address
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutdown <= 1'b0;
      halted <= 1'b0;
      exc_valid <= 1'b0;
      exc_vec <= sau_pkg::VEC_NONE;
      paddr_r <= 24'h000000;
      stack_pointer <= 16'h0000;
    end else begin
      if (in_exec && ex_shut) begin
        shutdown <= 1'b1;
      end else if (in_exec && cmd.op == sau_pkg::OP_NMI && nmi_ok) begin
        shutdown <= 1'b0;
      end
      if (in_exec && cmd.op == sau_pkg::OP_HALT) begin
        halted <= 1'b1;
      end else if (in_exec && (cmd.op == sau_pkg::OP_NMI || cmd.op == sau_pkg::OP_INT)) begin
        halted <= 1'b0;
      end
      // A new exception wins over a clear in the same cycle
      if (in_exec && ex_raise && !ex_shut) begin
        exc_valid <= 1'b1;
        exc_vec <= ex_vec;
      end else if (wr_en && paddr == sau_pkg::OFF_STAT && pwdata[sau_pkg::STAT_EXC_BIT]) begin
        exc_valid <= 1'b0;
      end
      // Every issued cycle, boot, halt and shutdown too; faults that do not shut down issue none
      if (bus_go) begin
        paddr_r <= bus_req.addr;
      end
      if (wr_en && paddr == sau_pkg::OFF_STACK_POINTER && !busy) begin
        stack_pointer <= pwdata[15:0];
      end else if (in_exec && cmd.stack && !ex_shut
                   && (cmd.op == sau_pkg::OP_ACCESS || cmd.op == sau_pkg::OP_INT)) begin
        // Pushes move the pointer even when they raise an exception, but not when they enter shutdown
        stack_pointer <= 16'(stack_pointer - sau_pkg::STACK_STEP);
      end
    end
  end

endmodule

/* verif/sau_mem_model.sv */
// Memory and local bus partner of the segment address unit.
// Assumes the unit holds each request until mem_ready is seen.
`timescale 1ns/1ps
module sau_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_valid,
  input wire sau_pkg::sau_bus_s mem_bus,
  input wire logic [3:0] wait_cycles,
  input wire logic use24,
  output logic mem_ready,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [logic [23:0]];
  logic [23:0] key;
  logic [3:0] cnt;
  // Top four lines mean nothing in real mode
  assign key = use24 ? mem_bus.addr : {4'h0, mem_bus.addr[19:0]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ready <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 16'h0;
    end else if (mem_ready || !mem_valid) begin
      mem_ready <= 1'b0;
      cnt <= 4'h0;
      // Released data never keeps its last value
      mem_rdata <= ~mem_rdata;
    end else if (cnt == wait_cycles) begin
      mem_ready <= 1'b1;
      mem_rdata <= mem.exists(key) ? mem[key] : 16'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

/* verif/sau_monitor.sv */
// Assertion checker for the segment address unit top ports.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/1ps
module sau_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_ready,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_valid,
  input wire sau_pkg::sau_bus_s mem_bus,
  input wire logic mem_lock
);
  logic [23:0] last_addr;
  logic [2:0] lock_reads;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_addr <= 24'h0;
    end else if (mem_valid && mem_ready) begin
      last_addr <= mem_bus.addr;
    end
  end
  // Completed reads inside one locked span
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reads <= 3'h0;
    end else if (!mem_lock) begin
      lock_reads <= 3'h0;
    end else if (mem_valid && mem_ready) begin
      lock_reads <= lock_reads + 3'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reset_quiet_a: assert property ($rose(presetn) |-> !mem_valid && !mem_lock)
    else $error("bus active at reset release");
  boot_fetch_a: assert property ($rose(presetn) |-> ##[1:3]
    (mem_valid && mem_bus.addr == 24'h0ffff0 && !mem_bus.halt))
    else $error("first fetch address wrong");
  idle_zero_a: assert property (!mem_valid |-> mem_bus == '0)
    else $error("bus lines not idle");
  bus_hold_a: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_bus))
    else $error("bus request changed before ready");
  byte_high_a: assert property (mem_valid && !mem_bus.halt && mem_bus.addr[0]
    |-> !mem_bus.byte_high_enable_n)
    else $error("odd byte without byte high enable");
  halt_code_a: assert property (mem_valid && mem_bus.halt
    |-> (mem_bus.addr == 24'h2 || mem_bus.addr == 24'h0) && !mem_lock)
    else $error("halt cycle address wrong");
  lock_span_a: assert property ($fell(mem_lock) |-> lock_reads == 3'h4)
    else $error("lock released early");
  desc_step_a: assert property ($rose(mem_valid) && mem_lock && lock_reads != 3'h0
    |-> mem_bus.addr == last_addr + 24'h2)
    else $error("descriptor words not consecutive");
endmodule
bind sau_top sau_monitor i_sau_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
  .mem_valid(mem_valid), .mem_bus(mem_bus), .mem_lock(mem_lock));

/* verif/segment_address_mode_unit_tb_top.sv */
// Testbench for the segment address unit: APB command sequences.
// Assumes the memory model answers every local bus cycle.
`timescale 1ns/1ps
module segment_address_mode_unit_tb_top;
  localparam logic [7:0] STA = sau_pkg::OFF_STAT;
  localparam logic [7:0] PAD = sau_pkg::OFF_PADDR;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic err;
  logic mem_ready;
  logic [15:0] mem_rdata;
  logic mem_valid;
  sau_pkg::sau_bus_s mem_bus;
  logic [3:0] mem_wait = 4'h0;
  logic use24 = 1'b0;
  logic [31:0] r;
  logic [31:0] args [3] = '{32'hffff0010, 32'hf000fff0, 32'h12340005};
  logic [31:0] exps [3] = '{32'h00000, 32'hffff0, 32'h12345};
  int mismatches = 0;
  int checked = 0;
  always #2.5 pclk = ~pclk;
  sau_top i_sau_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_ready(mem_ready), .mem_rdata(mem_rdata), .mem_valid(mem_valid),
    .mem_bus(mem_bus), .mem_lock());
  sau_mem_model i_sau_mem_model (.pclk(pclk), .presetn(presetn), .mem_valid(mem_valid),
    .mem_bus(mem_bus), .wait_cycles(mem_wait), .use24(use24), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata));
  task automatic print_verdict();
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic give_up();
    mismatches++;
    print_verdict();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) give_up();
      @(posedge pclk);
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    checked++;
    if ((r & m) !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, r & m, e);
    end
  endtask
  // Busy poll is bounded; a stuck unit ends the run
  task automatic idle();
    for (int n = 0; n < 200; n++) begin
      apb(1'b0, STA, 32'h0);
      if (r[0] === 1'b0) return;
    end
    give_up();
  endtask
  task automatic cmd(input logic [31:0] arg, input logic [31:0] c);
    apb(1'b1, sau_pkg::OFF_ARG, arg);
    apb(1'b1, sau_pkg::OFF_CMD, c);
    idle();
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    idle();
  endtask
  initial begin
    i_sau_mem_model.mem[24'h100012] = 16'h5678;
    i_sau_mem_model.mem[24'h100014] = 16'h8034;
    i_sau_mem_model.mem[24'h345778] = 16'h9abc;
    do_reset();
    chk(sau_pkg::OFF_STATUS_WORD, ALL, 32'hfff0);
    chk(sau_pkg::OFF_VTB, ALL, 32'h0);
    chk(sau_pkg::OFF_VTL, ALL, 32'h3ff);
    chk(PAD, ALL, 32'h0ffff0);
    apb(1'b0, 8'h30, 32'h0);
    checked++;
    if (err !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, err, 1'b1);
    end
    mem_wait <= 4'h3;
    for (int i = 0; i < 3; i++) begin
      cmd(args[i], 32'h01);
      chk(PAD, ALL, exps[i]);
    end
    cmd(32'hffff, 32'h11);
    chk(STA, 32'hff10, 32'h0d10);
    chk(PAD, ALL, 32'h12345);
    cmd(32'h0, 32'h08);
    chk(STA, 32'hff10, 32'h0910);
    cmd(32'h21, 32'h05);
    chk(PAD, ALL, 32'h84);
    apb(1'b1, sau_pkg::OFF_LIM, 32'hf);
    cmd(32'h2000, 32'h03);
    chk(sau_pkg::OFF_VTB, ALL, 32'h2000);
    cmd(32'h3, 32'h05);
    chk(PAD, ALL, 32'h200c);
    apb(1'b1, sau_pkg::OFF_STACK_POINTER, 32'h5);
    cmd(32'hffff, 32'h11);
    chk(STA, 32'h4, 32'h4);
    chk(PAD, ALL, 32'h0);
    cmd(32'h0, 32'h06);
    chk(STA, 32'h4, 32'h4);
    apb(1'b1, sau_pkg::OFF_STACK_POINTER, 32'h6);
    cmd(32'h0, 32'h06);
    chk(STA, 32'h4, 32'h0);
    cmd(32'h0, 32'h07);
    chk(PAD, ALL, 32'h2);
    cmd(32'h0, 32'h06);
    apb(1'b1, sau_pkg::OFF_LIM, 32'h3ff);
    cmd(32'h0, 32'h03);
    apb(1'b1, sau_pkg::OFF_STACK_POINTER, 32'h0);
    cmd(32'h0, 32'h31);
    chk(STA, 32'hff14, 32'h0d10);
    chk(sau_pkg::OFF_STACK_POINTER, ALL, 32'hfffe);
    apb(1'b1, sau_pkg::OFF_STACK_POINTER, 32'h1);
    cmd(32'h0, 32'h31);
    chk(STA, 32'h4, 32'h4);
    do_reset();
    chk(STA, 32'h6, 32'h0);
    use24 <= 1'b1;
    cmd(32'hfff1, 32'h04);
    chk(STA, 32'h2, 32'h2);
    cmd(32'hfff0, 32'h04);
    chk(sau_pkg::OFF_STATUS_WORD, 32'h1, 32'h1);
    apb(1'b1, sau_pkg::OFF_DTB, 32'h100000);
    cmd(32'h00100000, 32'h02);
    chk(sau_pkg::OFF_SEGB, 32'h1ffffff, 32'h1345678);
    cmd(32'h00100100, 32'h01);
    chk(PAD, ALL, 32'h345778);
    chk(sau_pkg::OFF_RDATA, ALL, 32'h9abc);
    cmd(32'h00180000, 32'h02);
    cmd(32'h00180000, 32'h01);
    chk(STA, 32'hff10, 32'h0b10);
    print_verdict();
  end
endmodule
